// [dv/sgr_host.sv]
`timescale 1ns/1ps
`default_nettype none

module sgr_host (
    input  wire logic              clock,
    output var sgr_pkg::sgr_pins_t pins,
    output logic [3:0]             byte_mask,
    output logic [31:0]            dq_in
);
    // ----------------------------------------------------------------
    // command issue, one command per edge
    // ----------------------------------------------------------------
    initial begin
        pins      = {1'b0, 3'h7, 2'h0, 10'h000};
        byte_mask = 4'hF;
        dq_in     = 32'h0000_0000;
    end

    task cmd(input logic [2:0] rcw, input logic sfs, input logic ba,
             input logic [9:0] a, input logic [31:0] d);
        @(posedge clock);
        pins  <= {1'b0, rcw, sfs, ba, a};
        dq_in <= d;
    endtask

    // act, setmode and refresh flip released data lines so stale data never looks valid
    task nop(input logic [31:0] d);
        cmd(3'h7, 1'b0, 1'b0, 10'h000, d);
    endtask

    task act(input logic ba, input logic [9:0] row);
        cmd(3'h3, 1'b0, ba, row, ~dq_in);
    endtask

    // callers pass one load enable only, never both
    task sload(input logic [9:0] a, input logic [31:0] d);
        cmd(3'h0, 1'b1, 1'b0, a, d);
    endtask

    task setmode(input logic [9:0] m);
        cmd(3'h2, 1'b0, 1'b0, 10'h100, ~dq_in);
        cmd(3'h0, 1'b0, 1'b0, m, ~dq_in);
        nop(~dq_in);
        nop(~dq_in);
    endtask

    // pause shortened: the count is ours, not the device's
    task init(input logic [9:0] m);
        repeat (4) nop(dq_in);
        byte_mask <= 4'h0;
        setmode(m);
        repeat (8) cmd(3'h1, 1'b0, 1'b0, 10'h000, ~dq_in);
    endtask
endmodule

`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
    typedef struct packed {
        logic [2:0]  lat;
        logic        bt;
        logic [7:0]  col;
        logic [31:0] ord;
    } sgr_row_t;

    logic               clock      = 1'b0;
    logic               rst_n      = 1'b0;
    sgr_pkg::sgr_pins_t pins;
    logic [3:0]         byte_mask;
    logic [31:0]        dq_in;
    logic [31:0]        dq_out;
    logic               dq_oe;
    int                 mismatches = 0;
    int                 checked    = 0;
    sgr_row_t           rows [4]   = '{
        '{3'h2, 1'b0, 8'h06, 32'h0607_0405},
        '{3'h3, 1'b1, 8'h05, 32'h0504_0706},
        '{3'h2, 1'b1, 8'h03, 32'h0302_0100},
        '{3'h3, 1'b0, 8'h01, 32'h0102_0300}};

    always #4 clock = ~clock;

    sgr_host sgr_host_i (
        .clock     (clock),
        .pins      (pins),
        .byte_mask (byte_mask),
        .dq_in     (dq_in)
    );

    sgr_core sgr_core_i (
        .clock     (clock),
        .rst_n     (rst_n),
        .pins      (pins),
        .byte_mask (byte_mask),
        .dq_in     (dq_in),
        .dq_out    (dq_out),
        .dq_oe     (dq_oe)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] pat(input logic [7:0] c);
        return {24'hA5C3E1, c};
    endfunction

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task close_out;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task wr4(input logic [7:0] c);
        sgr_host_i.cmd(3'h4, 1'b0, 1'b0, {2'h0, c}, pat(c));
        for (int k = 1; k < 4; k++) begin
            sgr_host_i.nop(pat(c + 8'(k)));
        end
    endtask

    task automatic rd4(input logic [7:0] c, input logic [2:0] lat,
                       input logic [3:0][31:0] w);
        sgr_host_i.cmd(3'h5, 1'b0, 1'b0, {2'h0, c}, ~dq_in);
        sgr_host_i.nop(~dq_in);
        repeat (lat - 3'h1) @(posedge clock);
        #1 chk("drive_early", 32'h1, {31'h0, dq_oe});
        for (int k = 3; k >= 0; k--) begin
            @(posedge clock);
            #1 chk("read_word", w[k], dq_out);
        end
        @(posedge clock);
        #1 chk("drive_off", 32'h0, {31'h0, dq_oe});
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        #1 chk("oe_reset", 32'h0, {31'h0, dq_oe});
        chk("out_reset", 32'h0, dq_out);
        sgr_host_i.init({2'h0, 1'b1, 3'h2, 1'b0, 3'h2});
        sgr_host_i.sload(10'h040, 32'hC0C0_C0C0);
        sgr_host_i.sload(10'h0C0, 32'hC1C1_C1C1);
        sgr_host_i.sload(10'h020, 32'hFFFF_FFFF);
        sgr_host_i.act(1'b0, 10'h005);
        wr4(8'h00);
        wr4(8'h04);
        foreach (rows[i]) begin
            sgr_host_i.setmode({2'h0, 1'b1, rows[i].lat, rows[i].bt, 3'h2});
            sgr_host_i.act(1'b0, 10'h005);
            rd4(rows[i].col, rows[i].lat, {pat(rows[i].ord[31:24]),
                pat(rows[i].ord[23:16]), pat(rows[i].ord[15:8]),
                pat(rows[i].ord[7:0])});
        end
        // block writes: A0 picks the color, data lines mask columns
        sgr_host_i.setmode({2'h0, 1'b1, 3'h2, 1'b0, 3'h2});
        sgr_host_i.act(1'b0, 10'h005);
        sgr_host_i.cmd(3'h4, 1'b1, 1'b0, 10'h009, 32'h0000_000F);
        sgr_host_i.cmd(3'h4, 1'b1, 1'b0, 10'h008, 32'h0000_00F0);
        rd4(8'h08, 3'h2, {4{32'hC1C1_C1C1}});
        rd4(8'h0C, 3'h2, {4{32'hC0C0_C0C0}});
        // single write under write-per-bit: one column, low half only
        sgr_host_i.sload(10'h020, 32'h0000_FFFF);
        sgr_host_i.setmode({2'h1, 1'b1, 3'h2, 1'b0, 3'h2});
        sgr_host_i.cmd(3'h3, 1'b1, 1'b0, 10'h005, ~dq_in);
        sgr_host_i.cmd(3'h4, 1'b0, 1'b0, 10'h008, 32'h1234_5678);
        sgr_host_i.nop(32'hDEAD_BEEF);
        rd4(8'h08, 3'h2, {32'hC1C1_5678, {3{32'hC1C1_C1C1}}});
        // terminate cuts a read burst short of its four words
        sgr_host_i.cmd(3'h5, 1'b0, 1'b0, 10'h000, ~dq_in);
        sgr_host_i.cmd(3'h6, 1'b0, 1'b0, 10'h000, ~dq_in);
        sgr_host_i.nop(~dq_in);
        repeat (3) @(posedge clock);
        #1 chk("cut_read", 32'h0, {31'h0, dq_oe});
        // read after the row is closed must stay silent
        sgr_host_i.cmd(3'h2, 1'b0, 1'b0, 10'h000, ~dq_in);
        sgr_host_i.cmd(3'h5, 1'b0, 1'b0, 10'h000, ~dq_in);
        sgr_host_i.nop(~dq_in);
        repeat (3) @(posedge clock);
        #1 chk("closed_read", 32'h0, {31'h0, dq_oe});
        close_out;
    end

    // generous bound: whole sequence is under 150 cycles
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        close_out;
    end
endmodule

`default_nettype wire

// [pkg/sgr_cfg.svh]
`ifndef SGR_CFG_SVH
`define SGR_CFG_SVH

// ----------------------------------------------------------------
// mode register encodings
// ----------------------------------------------------------------
`define SGR_BL_1      3'h0
`define SGR_BL_2      3'h1
`define SGR_BL_4      3'h2
`define SGR_BL_8      3'h3
`define SGR_BL_FULL   3'h7
`define SGR_LAT_2     3'h2
`define SGR_LAT_3     3'h3
`define SGR_FULL_PAGE 9'h100

// ----------------------------------------------------------------
// special load opcodes on the address lines, and the precharge all-banks bit
// ----------------------------------------------------------------
`define SGR_SPL_MASK   10'h020
`define SGR_SPL_COLOR0 10'h040
`define SGR_SPL_COLOR1 10'h0C0
`define SGR_SPL_SELECT 10'h080
`define SGR_ALL_BANKS  8

`endif

// [pkg/sgr_pkg.sv]
package sgr_pkg;

    typedef struct packed {
        logic       cs_n;
        logic       ras_n;
        logic       cas_n;
        logic       we_n;
        logic       special_function_select;
        logic       bank_select;
        logic [9:0] addr;
    } sgr_pins_t;

    // bit order follows the mode word, high bit first
    typedef struct packed {
        logic       opmode_high_bit;
        logic       single_write_mode_bit;
        logic       two_color_mode_bit;
        logic [2:0] latency;
        logic       burst_type_bit;
        logic [2:0] burst_len;
    } sgr_mode_t;

    typedef enum logic [3:0] {
        CMD_NOP, CMD_MODE_LOAD, CMD_SPECIAL_LOAD, CMD_ACTIVATE,
        CMD_ACTIVATE_WPB, CMD_READ, CMD_WRITE, CMD_BLOCK_WRITE,
        CMD_TERMINATE, CMD_PRECHARGE, CMD_REFRESH
    } sgr_cmd_t;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} sgr_state_t;

endpackage

// [rtl/sgr_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sgr_cfg.svh"

module sgr_core #(
    parameter int ROWS  = 1024,
    parameter int COLS  = 256,
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire sgr_pkg::sgr_pins_t pins,
    input  wire logic [3:0]        byte_mask,
    input  wire logic [WIDTH-1:0]  dq_in,
    output logic [WIDTH-1:0]       dq_out,
    output logic                   dq_oe
);
    localparam int RA = $clog2(ROWS);
    localparam int CA = $clog2(COLS);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic sgr_pkg::sgr_cmd_t decode(sgr_pkg::sgr_pins_t p);
        logic [2:0] rcw;
        rcw = {p.ras_n, p.cas_n, p.we_n};
        decode = sgr_pkg::CMD_NOP;
        if (!p.cs_n) begin
            case (rcw)
                3'h0: decode = p.special_function_select ?
                    sgr_pkg::CMD_SPECIAL_LOAD : sgr_pkg::CMD_MODE_LOAD;
                3'h1: decode = sgr_pkg::CMD_REFRESH;
                3'h2: decode = sgr_pkg::CMD_PRECHARGE;
                3'h3: decode = p.special_function_select ?
                    sgr_pkg::CMD_ACTIVATE_WPB : sgr_pkg::CMD_ACTIVATE;
                3'h4: decode = p.special_function_select ?
                    sgr_pkg::CMD_BLOCK_WRITE : sgr_pkg::CMD_WRITE;
                3'h5: decode = sgr_pkg::CMD_READ;
                3'h6: decode = sgr_pkg::CMD_TERMINATE;
                default: decode = sgr_pkg::CMD_NOP;
            endcase
        end
    endfunction

    function automatic logic [8:0] beats_of(input logic [2:0] bl);
        case (bl)
            `SGR_BL_2:    beats_of = 9'h002;
            `SGR_BL_4:    beats_of = 9'h004;
            `SGR_BL_8:    beats_of = 9'h008;
            `SGR_BL_FULL: beats_of = `SGR_FULL_PAGE;
            default:      beats_of = 9'h001;
        endcase
    endfunction

    // column of beat k; upper bits fix the block, low bits wrap
    function automatic logic [CA-1:0] burst_col(input logic [CA-1:0] st,
            input logic [8:0] k, input logic [2:0] bl, input logic bt);
        logic [CA-1:0] m;
        logic [CA-1:0] off;
        case (bl)
            `SGR_BL_2:    m = CA'(1);
            `SGR_BL_4:    m = CA'(3);
            `SGR_BL_8:    m = CA'(7);
            `SGR_BL_FULL: m = '1;
            default:      m = '0;
        endcase
        // full page has no interleaved order, force sequential
        if (bt && bl != `SGR_BL_FULL) begin
            off = st ^ CA'(k);
        end else begin
            off = st + CA'(k);
        end
        burst_col = (st & ~m) | (off & m);
    endfunction

    function automatic logic [WIDTH-1:0] bits_of(input logic [3:0] bm,
            input logic wpb, input logic [WIDTH-1:0] mask);
        logic [WIDTH-1:0] b;
        b = '1;
        for (int i = 0; i < 4; i++) begin
            if (bm[i]) b[i*8 +: 8] = 8'h00;
        end
        bits_of = wpb ? (b & mask) : b;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [WIDTH-1:0]     mem_q [2][ROWS*COLS];
    sgr_pkg::sgr_mode_t   mode_q;
    logic                 mode_ok_q;
    logic [WIDTH-1:0]     color0_q;
    logic [WIDTH-1:0]     color1_q;
    logic [WIDTH-1:0]     mask_q;
    logic [RA-1:0]        row_q [2];
    logic [1:0]           open_q;
    logic [1:0]           wpb_q;
    sgr_pkg::sgr_state_t  state_q;
    logic                 ebank_q;
    logic [CA-1:0]        start_q;
    logic [8:0]           beat_q;
    logic [8:0]           beats_q;
    logic                 beat_d1_q;
    logic                 beat_d2_q;
    logic [WIDTH-1:0]     dq_out_q;
    logic                 dq_oe_q;

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    wire sgr_pkg::sgr_cmd_t cmd = decode(pins);
    wire       bank  = pins.bank_select;
    wire [9:0] addr  = pins.addr;
    wire       lat3  = mode_q.latency == `SGR_LAT_3;
    // no read or write reaches the array until a mode word has been loaded
    wire       can_x = mode_ok_q && open_q[bank];
    wire       rd_go = cmd == sgr_pkg::CMD_READ && can_x;
    wire       wr_go = cmd == sgr_pkg::CMD_WRITE && can_x;
    wire       bw_go = cmd == sgr_pkg::CMD_BLOCK_WRITE && can_x;
    wire       spl   = cmd == sgr_pkg::CMD_SPECIAL_LOAD;
    wire       two_c = mode_ok_q && mode_q.two_color_mode_bit;
    wire [8:0] rd_n  = beats_of(mode_q.burst_len);
    wire [8:0] wr_n  = mode_q.single_write_mode_bit ? 9'h001 : rd_n;

    // overlapping load enables match no opcode and load nothing
    wire ld_c0 = spl && (two_c ? addr == `SGR_SPL_COLOR0
                 : (addr & ~`SGR_SPL_SELECT) == `SGR_SPL_COLOR0);
    wire ld_c1 = spl && two_c && addr == `SGR_SPL_COLOR1;
    wire ld_mk = spl && addr == `SGR_SPL_MASK;

    // ----------------------------------------------------------------
    // burst engine
    // ----------------------------------------------------------------
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [WIDTH-1:0] fifo_out_data;

    wire rd_beat = state_q == sgr_pkg::ST_READ && fifo_in_ready;
    wire wr_beat = state_q == sgr_pkg::ST_WRITE;
    wire [CA-1:0] e_col = burst_col(start_q, beat_q, mode_q.burst_len,
                                    mode_q.burst_type_bit);
    wire [RA+CA-1:0] e_idx = {row_q[ebank_q], e_col};
    wire [WIDTH-1:0] rd_word = mem_q[ebank_q][e_idx];
    wire [8:0] beat_nx = beat_q + 9'h001;
    wire pop = (lat3 ? beat_d2_q : beat_d1_q) && fifo_out_valid;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= sgr_pkg::ST_IDLE;
            ebank_q <= 1'b0;
            start_q <= '0;
            beat_q  <= '0;
            beats_q <= '0;
        end else if (rd_go) begin
            state_q <= sgr_pkg::ST_READ;
            ebank_q <= bank;
            start_q <= addr[CA-1:0];
            beat_q  <= '0;
            beats_q <= rd_n;
        end else if (wr_go) begin
            state_q <= (wr_n == 9'h001) ? sgr_pkg::ST_IDLE
                                        : sgr_pkg::ST_WRITE;
            ebank_q <= bank;
            start_q <= addr[CA-1:0];
            beat_q  <= 9'h001;
            beats_q <= wr_n;
        end else if (cmd == sgr_pkg::CMD_TERMINATE
                     || cmd == sgr_pkg::CMD_PRECHARGE || bw_go) begin
            state_q <= sgr_pkg::ST_IDLE;
        end else if (rd_beat || wr_beat) begin
            beat_q <= beat_nx;
            if (beat_nx == beats_q) state_q <= sgr_pkg::ST_IDLE;
        end
    end

    // ----------------------------------------------------------------
    // array writes
    // ----------------------------------------------------------------
    wire [WIDTH-1:0] wbits = bits_of(byte_mask, wpb_q[bank], mask_q);
    wire [WIDTH-1:0] ebits = bits_of(byte_mask, wpb_q[ebank_q], mask_q);
    wire [WIDTH-1:0] color = (two_c && addr[0]) ? color1_q : color0_q;
    wire [RA+CA-1:0] c_idx = {row_q[bank], addr[CA-1:0]};

    always_ff @(posedge clock) begin
        if (wr_go) begin
            mem_q[bank][c_idx] <= (mem_q[bank][c_idx] & ~wbits)
                                | (dq_in & wbits);
        end else if (bw_go) begin
            for (int i = 0; i < 8; i++) begin
                if (dq_in[i]) begin
                    mem_q[bank][{row_q[bank], addr[CA-1:3], 3'(i)}] <=
                        (mem_q[bank][{row_q[bank], addr[CA-1:3], 3'(i)}]
                         & ~wbits) | (color & wbits);
                end
            end
        end else if (wr_beat) begin
            mem_q[ebank_q][e_idx] <= (mem_q[ebank_q][e_idx] & ~ebits)
                                   | (dq_in & ebits);
        end
    end

    // ----------------------------------------------------------------
    // mode, special and bank registers
    // ----------------------------------------------------------------
    // mode, color and mask words have no reset: they only change on load
    always_ff @(posedge clock) begin
        if (cmd == sgr_pkg::CMD_MODE_LOAD) mode_q <= addr;
        if (ld_c0) color0_q <= dq_in;
        if (ld_c1) color1_q <= dq_in;
        if (ld_mk) mask_q <= dq_in;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mode_ok_q <= 1'b0;
            open_q    <= '0;
            wpb_q     <= '0;
            row_q[0]  <= '0;
            row_q[1]  <= '0;
        end else begin
            if (cmd == sgr_pkg::CMD_MODE_LOAD) mode_ok_q <= 1'b1;
            if (cmd == sgr_pkg::CMD_ACTIVATE
                || cmd == sgr_pkg::CMD_ACTIVATE_WPB) begin
                row_q[bank]  <= addr[RA-1:0];
                open_q[bank] <= 1'b1;
                wpb_q[bank]  <= cmd == sgr_pkg::CMD_ACTIVATE_WPB;
            end else if (cmd == sgr_pkg::CMD_PRECHARGE) begin
                if (addr[`SGR_ALL_BANKS]) open_q <= '0;
                else open_q[bank] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    sgr_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (state_q == sgr_pkg::ST_READ),
        .in_ready  (fifo_in_ready),
        .in_data   (rd_word),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_out_data)
    );

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            beat_d1_q <= 1'b0;
            beat_d2_q <= 1'b0;
            dq_oe_q   <= 1'b0;
            dq_out_q  <= '0;
        end else begin
            beat_d1_q <= rd_beat;
            beat_d2_q <= beat_d1_q;
            // enable rises one edge ahead of the first word
            dq_oe_q   <= (lat3 ? beat_d1_q : rd_beat) | pop;
            if (pop) dq_out_q <= fifo_out_data;
        end
    end

    assign dq_out = dq_out_q;
    assign dq_oe  = dq_oe_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_rd_lat2;
        @(posedge clock) disable iff (!rst_n)
        rd_go && !lat3 && fifo_in_ready |-> ##2 dq_oe_q;
    endproperty
    a_rd_lat2: assert property (p_rd_lat2)
        else $error("latency 2 read did not enable outputs");

    property p_rd_lat3;
        @(posedge clock) disable iff (!rst_n)
        rd_go && lat3 && fifo_in_ready && !dq_oe_q && !beat_d1_q
            && !rd_beat |-> ##2 !dq_oe_q ##1 dq_oe_q;
    endproperty
    a_rd_lat3: assert property (p_rd_lat3)
        else $error("latency 3 read enabled outputs at wrong edge");

    property p_color0;
        @(posedge clock) disable iff (!rst_n)
        ld_c0 |=> color0_q == $past(dq_in);
    endproperty
    a_color0: assert property (p_color0)
        else $error("color 0 not loaded");

    property p_color1;
        @(posedge clock) disable iff (!rst_n)
        spl && addr == `SGR_SPL_COLOR1 && mode_ok_q
            && mode_q.two_color_mode_bit |=> color1_q == $past(dq_in);
    endproperty
    a_color1: assert property (p_color1)
        else $error("color 1 not loaded");

    property p_mask;
        @(posedge clock) disable iff (!rst_n)
        spl && addr == `SGR_SPL_MASK |=> mask_q == $past(dq_in);
    endproperty
    a_mask: assert property (p_mask)
        else $error("mask not loaded");

    property p_color_hold;
        @(posedge clock) disable iff (!rst_n)
        !spl |=> $stable(color0_q) && $stable(color1_q);
    endproperty
    a_color_hold: assert property (p_color_hold)
        else $error("color register changed without load");

    property p_mask_hold;
        @(posedge clock) disable iff (!rst_n)
        !spl |=> $stable(mask_q);
    endproperty
    a_mask_hold: assert property (p_mask_hold)
        else $error("mask register changed without load");

    property p_mode;
        @(posedge clock) disable iff (!rst_n)
        cmd == sgr_pkg::CMD_MODE_LOAD |=> mode_q == $past(addr)
            && mode_ok_q;
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode word not loaded");

    property p_act;
        @(posedge clock) disable iff (!rst_n)
        cmd == sgr_pkg::CMD_ACTIVATE |=> open_q[$past(bank)]
            && row_q[$past(bank)] == $past(addr[RA-1:0]);
    endproperty
    a_act: assert property (p_act)
        else $error("activate did not open the row");

    property p_single_wr;
        @(posedge clock) disable iff (!rst_n)
        wr_go && mode_q.single_write_mode_bit
            |=> state_q == sgr_pkg::ST_IDLE;
    endproperty
    a_single_wr: assert property (p_single_wr)
        else $error("single write mode still bursting");

    property p_term;
        @(posedge clock) disable iff (!rst_n)
        cmd == sgr_pkg::CMD_TERMINATE |=> state_q == sgr_pkg::ST_IDLE;
    endproperty
    a_term: assert property (p_term)
        else $error("terminate did not stop the burst");

    c_read: cover property (@(posedge clock) disable iff (!rst_n)
        rd_go ##1 dq_oe_q[*3]);
    c_block: cover property (@(posedge clock) disable iff (!rst_n)
        bw_go && two_c);
    c_full: cover property (@(posedge clock) disable iff (!rst_n)
        wr_go && mode_q.burst_len == `SGR_BL_FULL);

endmodule

`default_nettype wire

// [rtl/sgr_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

module sgr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] buf_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;

    function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
        ptr_next = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = count_q != (AW+1)'(DEPTH);
    assign out_valid = count_q != '0;
    assign out_data  = buf_q[rd_ptr_q];

    always_ff @(posedge clock) begin
        if (push) begin
            buf_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) wr_ptr_q <= ptr_next(wr_ptr_q);
            if (pop) rd_ptr_q <= ptr_next(rd_ptr_q);
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule

`default_nettype wire
